// ---- verilog/adcs_pkg.sv ----
// Constants, types and helpers for the conversion sequencer
package adcs_pkg;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_RES_HIGH = 8'h04;
   localparam logic [7:0] OFF_RES_LOW = 8'h08;
   localparam logic [7:0] OFF_CLKSEL = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam int CTRL_ON_BIT = 0;
   localparam int CTRL_GO_BIT = 1;
   localparam int CTRL_CHS_LSB = 2;
   localparam int CHS_W = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int STAT_FLAG_BIT = 0;
   localparam int STAT_IRQEN_BIT = 1;
   localparam logic [2:0] CLKSEL_RESET = 3'h0;
   localparam int CKS_W = 3;
   localparam logic [2:0] CKS_DIV8 = 3'h1;
   localparam logic [2:0] CKS_DIV16 = 3'h5;
   localparam logic [2:0] CKS_DIV32 = 3'h2;
   localparam logic [2:0] CKS_DIV64 = 3'h6;
   localparam logic [1:0] CKS_RC_LOW = 2'h3;
   localparam int RC_OSC_DIV = 16;
   localparam int RESULT_W = 10;
   localparam int CONV_TADS = 11;
   localparam int ABORT_TADS = 2;
   localparam int INSTR_CLKS = 4;
   localparam logic [4:0] CHS_INT_LAST = 5'h0C;
   localparam logic [4:0] CHS_EXT_FIRST = 5'h10;
   localparam logic [4:0] CHS_EXT_LAST = 5'h17;

   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONVERT, ST_HOLDOFF}
      adcs_state_e;

   // Clocks of pclk per bit period for a clock-select code
   function automatic int adcs_div(input logic [2:0] sel);
      if (sel[1:0] == CKS_RC_LOW)
         return RC_OSC_DIV;
      case (sel)
         CKS_DIV16: return 16;
         CKS_DIV32: return 32;
         CKS_DIV64: return 64;
         default: return 8;
      endcase
   endfunction
endpackage

// ---- verilog/adcs_tad_gen.sv ----
// Bit-period tick generator
`timescale 1ns/1ps
module adcs_tad_gen (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [2:0] clk_sel,
   output logic tad_tick
);
   logic [6:0] cnt;
   logic [6:0] last;

   assign last = 7'(adcs_pkg::adcs_div(clk_sel) - 1);

   // Phase restarts whenever the sequencer stops counting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 7'h00;
         tad_tick <= 1'b0;
      end else if (!run) begin
         cnt <= 7'h00;
         tad_tick <= 1'b0;
      end else if (cnt == last) begin
         cnt <= 7'h00;
         tad_tick <= 1'b1;
      end else begin
         cnt <= cnt + 7'h01;
         tad_tick <= 1'b0;
      end
   end
endmodule

// ---- verilog/adcs_sar_core.sv ----
// Successive-approximation bit register
`timescale 1ns/1ps
module adcs_sar_core #(
   parameter int W = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic step,
   input wire logic comp,
   output logic [W-1:0] code,
   output logic done
);
   logic [W-1:0] mask;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code <= '0;
         mask <= '0;
         done <= 1'b0;
      end else if (load) begin
         code <= W'(1) << (W - 1);
         mask <= W'(1) << (W - 1);
         done <= 1'b0;
      end else if (step && mask != '0) begin
         // Comparator low means the trial overshot
         code <= (comp ? code : (code & ~mask)) | (mask >> 1);
         mask <= mask >> 1;
         done <= mask[0];
      end else begin
         done <= 1'b0;
      end
   end
endmodule

// ---- verilog/adcs_sequencer.sv ----
// Conversion sequencer top with APB register file
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module adcs_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_req,
   input wire logic comp_in,
   output logic [4:0] channel_select,
   output logic analog_on,
   output logic sample_hold,
   output logic [9:0] dac_code,
   output logic conversion_done,
   output logic wake
);
   logic comp_meta;
   logic comp_sync;
   logic converter_on;
   logic go;
   logic [4:0] chs;
   logic [2:0] clk_sel;
   logic done_flag;
   logic irq_en;
   logic sleep_off;
   logic [9:0] result;
   logic [3:0] tad_cnt;
   logic [2:0] dly_cnt;
   adcs_pkg::adcs_state_e state;
   logic tad_tick;
   logic sar_done;
   logic is_rc;
   logic busy;
   logic wr_acc;
   logic wr_ctrl;
   logic wr_stat;
   logic start_req;
   logic sw_abort;
   logic hard_abort;
   logic complete;
   logic sar_load;
   logic sar_step;

   function automatic logic reg_hit(input logic [7:0] a);
      return a == adcs_pkg::OFF_CTRL || a == adcs_pkg::OFF_RES_HIGH ||
         a == adcs_pkg::OFF_RES_LOW || a == adcs_pkg::OFF_CLKSEL ||
         a == adcs_pkg::OFF_STATUS;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comp_meta <= 1'b0;
         comp_sync <= 1'b0;
      end else begin
         comp_meta <= comp_in;
         comp_sync <= comp_meta;
      end
   end

   assign is_rc = clk_sel[1:0] == adcs_pkg::CKS_RC_LOW;
   assign busy = state == adcs_pkg::ST_DELAY ||
      state == adcs_pkg::ST_CONVERT;
   assign wr_acc = psel && penable && pready && pwrite;
   assign wr_ctrl = wr_acc && paddr == adcs_pkg::OFF_CTRL;
   assign wr_stat = wr_acc && paddr == adcs_pkg::OFF_STATUS;
   // Stored enable is used, so a combined enable+start write is dropped
   assign start_req = wr_ctrl && pwdata[adcs_pkg::CTRL_GO_BIT] &&
      converter_on && !sleep_off &&
      state == adcs_pkg::ST_IDLE;
   assign sw_abort = wr_ctrl && !pwdata[adcs_pkg::CTRL_GO_BIT] &&
      busy;
   // Disable or non-RC sleep kills the conversion with no hold-off
   assign hard_abort = (busy || state == adcs_pkg::ST_HOLDOFF) &&
      ((wr_ctrl && !pwdata[adcs_pkg::CTRL_ON_BIT]) ||
      (sleep_req && !is_rc));
   assign complete = sar_done && state == adcs_pkg::ST_CONVERT;
   assign sar_load = tad_tick && tad_cnt == 4'h0 &&
      state == adcs_pkg::ST_CONVERT;
   assign sar_step = tad_tick && tad_cnt != 4'h0 &&
      state == adcs_pkg::ST_CONVERT;

   adcs_tad_gen u_tad (
      .pclk(pclk),
      .presetn(presetn),
      .run((state == adcs_pkg::ST_CONVERT ||
         state == adcs_pkg::ST_HOLDOFF) && !sw_abort),
      .clk_sel(clk_sel),
      .tad_tick(tad_tick)
   );

   adcs_sar_core #(.W(adcs_pkg::RESULT_W)) u_sar (
      .pclk(pclk),
      .presetn(presetn),
      .load(sar_load),
      .step(sar_step),
      .comp(comp_sync),
      .code(dac_code),
      .done(sar_done)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= adcs_pkg::ST_IDLE;
         dly_cnt <= 3'h0;
      end else begin
         case (state)
            adcs_pkg::ST_IDLE: begin
               dly_cnt <= 3'h0;
               if (start_req)
                  state <= is_rc ? adcs_pkg::ST_DELAY
                     : adcs_pkg::ST_CONVERT;
            end
            adcs_pkg::ST_DELAY: begin
               dly_cnt <= dly_cnt + 3'h1;
               if (hard_abort)
                  state <= adcs_pkg::ST_IDLE;
               else if (sw_abort)
                  state <= adcs_pkg::ST_HOLDOFF;
               else if (dly_cnt == 3'(adcs_pkg::INSTR_CLKS - 1))
                  state <= adcs_pkg::ST_CONVERT;
            end
            adcs_pkg::ST_CONVERT: begin
               if (hard_abort)
                  state <= adcs_pkg::ST_IDLE;
               else if (sw_abort)
                  state <= adcs_pkg::ST_HOLDOFF;
               else if (complete)
                  state <= adcs_pkg::ST_IDLE;
            end
            adcs_pkg::ST_HOLDOFF: begin
               if (hard_abort)
                  state <= adcs_pkg::ST_IDLE;
               else if (tad_tick &&
                  tad_cnt == 4'(adcs_pkg::ABORT_TADS - 1))
                  state <= adcs_pkg::ST_IDLE;
            end
            default: state <= adcs_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tad_cnt <= 4'h0;
      else if (sw_abort || busy && state != adcs_pkg::ST_CONVERT ||
         state == adcs_pkg::ST_IDLE)
         tad_cnt <= 4'h0;
      else if (tad_tick)
         tad_cnt <= tad_cnt + 4'h1;
   end

   // Control, clock-select and status interrupt-enable register fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_on <= adcs_pkg::CTRL_RESET[adcs_pkg::CTRL_ON_BIT];
         chs <= adcs_pkg::CTRL_RESET[adcs_pkg::CTRL_CHS_LSB +:
            adcs_pkg::CHS_W];
         clk_sel <= adcs_pkg::CLKSEL_RESET;
         irq_en <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            converter_on <= pwdata[adcs_pkg::CTRL_ON_BIT];
            chs <= pwdata[adcs_pkg::CTRL_CHS_LSB +: adcs_pkg::CHS_W];
         end
         if (wr_acc && paddr == adcs_pkg::OFF_CLKSEL)
            clk_sel <= pwdata[adcs_pkg::CKS_W-1:0];
         if (wr_stat)
            irq_en <= pwdata[adcs_pkg::STAT_IRQEN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         go <= 1'b0;
      else if (start_req)
         go <= 1'b1;
      else if (complete || sw_abort || hard_abort ||
         (wr_ctrl && !pwdata[adcs_pkg::CTRL_GO_BIT]))
         go <= 1'b0;
   end

   // Completion beats a same-cycle software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         done_flag <= 1'b0;
      else if (complete)
         done_flag <= 1'b1;
      else if (wr_stat && !pwdata[adcs_pkg::STAT_FLAG_BIT])
         done_flag <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         result <= '0;
      else if (complete)
         result <= dac_code;
   end

   // Enable bit keeps reading one while the module is powered down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sleep_off <= 1'b0;
      else if (!sleep_req)
         sleep_off <= 1'b0;
      else if (!is_rc || (complete && !irq_en))
         sleep_off <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake <= 1'b0;
         analog_on <= 1'b0;
         sample_hold <= 1'b0;
         channel_select <= 5'h00;
         conversion_done <= 1'b0;
      end else begin
         wake <= complete && sleep_req && irq_en;
         analog_on <= converter_on && !sleep_off;
         // Input tracks the channel in idle and the start delay, not while converting or in hold-off
         sample_hold <= converter_on && !sleep_off &&
            (state == adcs_pkg::ST_IDLE ||
            state == adcs_pkg::ST_DELAY);
         channel_select <= chs;
         conversion_done <= done_flag;
      end
   end

   // Zero-wait APB: data is captured in setup, ready in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !reg_hit(paddr);
         if (psel && !penable) begin
            case (paddr)
               adcs_pkg::OFF_CTRL:
                  prdata <= {25'h0, chs, go, converter_on};
               adcs_pkg::OFF_RES_HIGH:
                  prdata <= {30'h0, result[9:8]};
               adcs_pkg::OFF_RES_LOW:
                  prdata <= {24'h0, result[7:0]};
               adcs_pkg::OFF_CLKSEL:
                  prdata <= {29'h0, clk_sel};
               adcs_pkg::OFF_STATUS:
                  prdata <= {27'h0, state == adcs_pkg::ST_HOLDOFF, busy,
                     sleep_off, irq_en, done_flag};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Helper: cycles spent in hold-off
   logic [8:0] hold_clks;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hold_clks <= 9'h000;
      else if (state == adcs_pkg::ST_HOLDOFF)
         hold_clks <= hold_clks + 9'h001;
      else
         hold_clks <= 9'h000;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_OFF_NO_START: assert property (
      wr_ctrl && pwdata[adcs_pkg::CTRL_GO_BIT] && !converter_on
      |=> state == adcs_pkg::ST_IDLE && !go)
      else $error("start accepted while converter off");
   AST_START: assert property (
      start_req && !is_rc |=> state == adcs_pkg::ST_CONVERT && go)
      else $error("start did not begin conversion");
   AST_COMPLETE: assert property (
      complete |=> !go && done_flag && result == $past(dac_code))
      else $error("completion effects missing");
   AST_ABORT: assert property (
      sw_abort && !hard_abort
      |=> state == adcs_pkg::ST_HOLDOFF && !go)
      else $error("software abort not honoured");
   AST_KEEP_RESULT: assert property (
      (sw_abort || hard_abort) && !complete |=> $stable(result))
      else $error("result changed after abort");
   AST_HOLD_LEN: assert property (
      state == adcs_pkg::ST_HOLDOFF ##1 state == adcs_pkg::ST_IDLE &&
      !$past(hard_abort)
      |-> $past(hold_clks) >= 9'(adcs_pkg::ABORT_TADS *
      adcs_pkg::adcs_div(clk_sel) - 1))
      else $error("hold-off shorter than two bit periods");
   AST_REACQUIRE: assert property (
      state == adcs_pkg::ST_HOLDOFF ##1 state == adcs_pkg::ST_IDLE &&
      converter_on && !sleep_off && !sleep_req |=> sample_hold)
      else $error("no acquisition after hold-off");
   AST_RC_DELAY: assert property (
      start_req && is_rc && !sleep_req
      |=> (state == adcs_pkg::ST_DELAY && !sw_abort && !hard_abort)[*4]
      ##1 state == adcs_pkg::ST_CONVERT)
      else $error("RC start delay wrong");
   AST_SLEEP_ABORT: assert property (
      busy && sleep_req && !is_rc
      |=> state == adcs_pkg::ST_IDLE && !go ##1 !analog_on)
      else $error("sleep did not abort conversion");
   AST_WAKE: assert property (
      complete && sleep_req && irq_en |=> wake)
      else $error("no wake on sleep completion");

   COV_COMPLETE: cover property (complete);
   COV_ABORT: cover property (sw_abort ##[1:200] state == adcs_pkg::ST_IDLE);
   COV_SLEEP_WAKE: cover property (wake);
   COV_SLEEP_OFF: cover property (complete && sleep_req && !irq_en);
endmodule

// ---- testbench/adcs_comp_model.sv ----
// Comparator stand-in: answers each trial code against a target level
`timescale 1ns/1ps
module adcs_comp_model (
   input wire logic pclk,
   input wire logic analog_on,
   input wire logic [9:0] dac_code,
   input wire logic [9:0] target,
   output logic comp_in
);
   logic idle_pat = 1'b0;

   // Unpowered comparator gives no steady level to lean on
   always @(posedge pclk) begin
      idle_pat <= ~idle_pat;
   end

   // Keep the trial bit while the trial code does not exceed the input
   assign comp_in = analog_on ? (dac_code <= target) : idle_pat;
endmodule

// ---- testbench/adc_conversion_sequencer_tb.sv ----
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_conversion_sequencer_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sleep_req = 1'b0;
   logic comp_in;
   logic analog_on;
   logic sample_hold;
   logic conversion_done;
   logic wake;
   logic [4:0] channel_select;
   logic [9:0] dac_code;
   logic [9:0] target = 10'h000;
   int fail_count = 0;
   int cmp_count = 0;
   int seed = 32'h0000_ff04;
   int wake_cnt = 0;
   int n;
   int t16;
   int trc;
   logic [31:0] rd;
   logic err;
   logic [31:0] r;
   logic [2:0] s;
   logic [4:0] ch;
   logic [2:0] sels [5] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3};

   adcs_sequencer i_adcs_sequencer (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_req(sleep_req), .comp_in(comp_in),
      .channel_select(channel_select), .analog_on(analog_on),
      .sample_hold(sample_hold), .dac_code(dac_code),
      .conversion_done(conversion_done), .wake(wake));

   adcs_comp_model i_adcs_comp_model (.pclk(pclk), .analog_on(analog_on),
      .dac_code(dac_code), .target(target), .comp_in(comp_in));

   initial begin
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (wake === 1'b1) wake_cnt++;
   end

   function automatic int tad(input logic [2:0] cs);
      if (cs[1:0] == 2'h3) return 16;
      case (cs)
         3'h5: return 16;
         3'h2: return 32;
         3'h6: return 64;
         default: return 8;
      endcase
   endfunction

   function automatic logic [31:0] ctrl(input logic [4:0] c, input logic go);
      return {24'h00_0000, 1'b0, c, go, 1'b1};
   endfunction

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, e)
   endtask

   task automatic wait_done(output int c);
      c = 0;
      while (conversion_done !== 1'b1 && c < 2000) begin
         @(posedge pclk);
         c++;
      end
      if (c >= 2000) fail_count++;
   endtask

   // Enable and start kept as two writes, flag cleared first
   task automatic start(input logic [2:0] cs, input logic [4:0] c,
                        input logic irq);
      apb(1'b1, 8'h0C, {29'h0000_0000, cs});
      apb(1'b1, 8'h10, {30'h0000_0000, irq, 1'b0});
      apb(1'b1, 8'h00, ctrl(c, 1'b0));
      repeat (4) @(posedge pclk);
      apb(1'b1, 8'h00, ctrl(c, 1'b1));
   endtask

   task automatic summarize();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge pclk);
      fail_count++;
      summarize();
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 5; a++) begin
         rdchk(8'(a * 4), 32'h0000_0000);
      end
      apb(1'b0, 8'h14, 32'h0000_0000);
      `CHK(err, 1'b1)
      apb(1'b1, 8'h00, 32'h0000_0002);
      rdchk(8'h00, 32'h0000_0000);
      apb(1'b1, 8'h00, 32'h0000_0003);
      rdchk(8'h00, 32'h0000_0001);
      for (int i = 0; i < 7; i++) begin
         r = $random(seed);
         s = sels[i % 5];
         ch = i[0] ? {2'b10, r[2:0]}
            : (r[3:0] > 4'hC ? 5'h0C : {1'b0, r[3:0]});
         target <= (i == 5) ? 10'h3FF : (i == 6) ? 10'h000 : r[17:8];
         start(s, ch, 1'b0);
         wait_done(n);
         `CHK(n >= 11 * tad(s) - 2 && n <= 11 * tad(s) + 8, 1'b1)
         if (s == 3'h5) t16 = n;
         if (s == 3'h3) trc = n;
         `CHK(channel_select, ch)
         rdchk(8'h00, ctrl(ch, 1'b0));
         rdchk(8'h04, {30'h0000_0000, target[9:8]});
         rdchk(8'h08, {24'h00_0000, target[7:0]});
         rdchk(8'h10, 32'h0000_0001);
      end
      `CHK(trc - t16, adcs_pkg::INSTR_CLKS)
      // Abort mid-conversion, old result must survive
      target <= 10'h155;
      start(3'h1, 5'h02, 1'b0);
      repeat (30) @(posedge pclk);
      rdchk(8'h00, ctrl(5'h02, 1'b1));
      apb(1'b1, 8'h00, ctrl(5'h02, 1'b0));
      rdchk(8'h10, 32'h0000_0010);
      n = 0;
      while (sample_hold !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      `CHK(n >= 8 && n <= 20, 1'b1)
      rdchk(8'h04, 32'h0000_0000);
      rdchk(8'h08, 32'h0000_0000);
      rdchk(8'h10, 32'h0000_0000);
      // Sleep with a divided system clock kills the conversion
      start(3'h1, 5'h03, 1'b0);
      repeat (20) @(posedge pclk);
      sleep_req <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK(analog_on, 1'b0)
      rdchk(8'h00, ctrl(5'h03, 1'b0));
      rdchk(8'h10, 32'h0000_0004);
      sleep_req <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(analog_on, 1'b1)
      // RC clock: conversion runs through sleep and wakes the core
      target <= 10'h2A5;
      start(3'h3, 5'h11, 1'b1);
      repeat (2) @(posedge pclk);
      sleep_req <= 1'b1;
      wait_done(n);
      @(posedge pclk);
      `CHK(wake_cnt, 1)
      sleep_req <= 1'b0;
      rdchk(8'h04, 32'h0000_0002);
      rdchk(8'h08, 32'h0000_00A5);
      // RC clock, interrupt off: powered down, enable still reads set
      start(3'h3, 5'h11, 1'b0);
      repeat (2) @(posedge pclk);
      sleep_req <= 1'b1;
      wait_done(n);
      repeat (2) @(posedge pclk);
      `CHK(analog_on, 1'b0)
      `CHK(wake_cnt, 1)
      rdchk(8'h00, ctrl(5'h11, 1'b0));
      sleep_req <= 1'b0;
      // Dropping enable mid-conversion stops it
      start(3'h1, 5'h04, 1'b0);
      repeat (10) @(posedge pclk);
      apb(1'b1, 8'h00, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      `CHK(analog_on, 1'b0)
      repeat (120) @(posedge pclk);
      rdchk(8'h10, 32'h0000_0000);
      // Reset in mid-conversion
      start(3'h1, 5'h05, 1'b0);
      repeat (10) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK({analog_on, sample_hold, conversion_done}, 3'h0)
      `CHK(dac_code, 10'h000)
      presetn <= 1'b1;
      rdchk(8'h00, 32'h0000_0000);
      rdchk(8'h08, 32'h0000_0000);
      summarize();
   end
endmodule
